// [rtl/sfs_pkg.sv]
// Constants and types of the switch fault status block
package sfs_pkg;
  localparam int CLK_MHZ         = 100;
  localparam int INT_PULSE_US    = 100;
  localparam real INT_RELEASE_MS = 1.0;
  localparam int INT_PULSE_CYC   = INT_PULSE_US * CLK_MHZ;
  localparam int INT_RELEASE_CYC = int'(INT_RELEASE_MS * 1000.0 * CLK_MHZ);
  localparam int TMR_W           = 17;
  localparam int FRAME_BITS      = 32;
  localparam int FAULT_W         = 11;

  localparam logic [6:0] ADDR_STATUS = 7'h1f;
  localparam logic [6:0] ADDR_FAULT  = 7'h21;
  localparam logic [6:0] ADDR_INTREQ = 7'h23;
  localparam logic [6:0] ADDR_RESET  = 7'h24;

  localparam int POS_SUMMARY = 23;
  localparam int POS_INTFLG  = 22;
  localparam int POS_SPI_ERR = 10;
  localparam int POS_HASH    = 9;
  localparam int POS_UV      = 7;
  localparam int POS_OV      = 6;
  localparam int POS_TWARN   = 5;
  localparam int POS_TLIM    = 4;
  localparam int POS_WK_INT  = 3;
  localparam int POS_WK_PIN  = 2;
  localparam int POS_WK_SPI  = 1;
  localparam int POS_POR     = 0;

  localparam logic [10:0] FAULT_RST     = 11'h001;
  localparam logic [10:0] FAULT_CMD_RST = 11'h000;
  localparam logic        INTFLG_RST    = 1'b1;
  localparam logic [2:0]  CS_SYNC_RST   = 3'h7;

  typedef struct packed {
    logic [6:0]  addr;
    logic        rw;
    logic [23:0] data;
  } sfs_frame_t;

  typedef struct packed {
    logic [7:0]  programmable_inputs;
    logic [13:0] ground_switch_inputs;
  } sfs_switch_t;

  typedef struct packed {
    logic supply_low_flag;
    logic supply_high_flag;
    logic thermal_warning_flag;
    logic thermal_limit_flag;
  } sfs_sense_t;

  typedef struct packed {
    logic int_pin_wake;
    logic wake_pin_wake;
    logic spi_msg_wake;
    logic por_event;
  } sfs_wake_t;

  typedef enum logic [2:0] {
    CMD_OTHER  = 3'h0,
    CMD_STATUS = 3'h1,
    CMD_FAULT  = 3'h3,
    CMD_INTREQ = 3'h2,
    CMD_RESET  = 3'h6
  } sfs_cmd_t;
endpackage

// [rtl/sfs_top.sv]
// Switch fault status block: SPI frame link, fault flags, interrupt output
// Operation
// R01: Response bit 23 is high whenever any fault flag is recorded.
// R02: Response bit 22 shows whether a change of state was detected.
// R03: Bits 21..0 return programmable then ground inputs, one meaning closed.
// R04: Fault flags appear in the reply to the frame after a fault read.
// R05: Bit 10 sets on malformed frames, clears on read without error.
// R06: Bit 9 sets on hash mismatch, clears after read without mismatch.
// R07: Bit 7 sets on supply low, clears after recovery and read.
// R08: Bit 6 sets on supply high, clears after recovery and read.
// R09: Bits 5 and 4 follow thermal warning and limit, clear after read.
// R10: Wake sources set bits 3, 2, 1; each clears when read.
// R11: Bit 0 records a power-on event and clears when read.
// R12: Change flag sets on input change or new fault, clears on read.
// R13: Interrupt request command gives one 100 us low pulse on interrupt.
// R14: Interrupt request reply echoes command word with summary and change.
// R15: An interrupt request by itself never sets the change flag.
// R16: Reset command with zero data returns registers to defaults.
// R17: Reply after a reset command is the switch status frame.
// R18: Frame starts at chip select fall and lasts 32 serial clocks.
// R19: Reading the switch status clears the change flag.
// R20: Summary bit stays set until the fault register is read.
// R21: Interrupt releases 1.0 ms after select falls, reasserts on faults.
module sfs_top
  import sfs_pkg::*;
#(
  parameter int unsigned PULSE_CYC   = sfs_pkg::INT_PULSE_CYC,
  parameter int unsigned RELEASE_CYC = sfs_pkg::INT_RELEASE_CYC
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          sclk,
  input  wire logic          cs_b,
  input  wire logic          mosi,
  output logic               miso,
  output logic               miso_oe,
  output logic               int_b,
  input  sfs_pkg::sfs_switch_t sw_in,
  input  sfs_pkg::sfs_sense_t  sense_in,
  input  wire logic          hash_mismatch,
  input  sfs_pkg::sfs_wake_t   wake_evt
);
  import sfs_pkg::*;

  // Link side state cleared by chip select
  typedef struct packed {
    logic [4:0]  cnt;
    logic        oe;
    logic        miso;
    logic [30:0] tx;
    logic [30:0] sh;
  } sfs_lnk_a_t;

  // Link side state that must survive between frames
  typedef struct packed {
    logic       st_tg;
    logic       dn_tg;
    sfs_frame_t rx;
  } sfs_lnk_b_t;

  typedef struct packed {
    logic [2:0]         cs_s;
    logic [2:0]         st_s;
    logic [2:0]         dn_s;
    sfs_sense_t         sns_a;
    sfs_sense_t         sns_b;
    sfs_switch_t        sw_a;
    sfs_switch_t        sw_b;
    sfs_switch_t        sw_prev;
    logic [1:0]         starts;
    logic [1:0]         dones;
    sfs_cmd_t           prev;
    logic [7:0]         prev_hdr;
    logic [FAULT_W-1:0] fault;
    logic               intflg;
    logic [31:0]        resp;
    logic               int_low;
    logic               rel_run;
    logic [TMR_W-1:0]   rel_cnt;
    logic [TMR_W-1:0]   pulse_cnt;
    logic               int_b;
  } sfs_core_t;

  sfs_lnk_a_t         la_q;
  sfs_lnk_a_t         la_d;
  sfs_lnk_b_t         lb_q;
  sfs_lnk_b_t         lb_d;
  sfs_core_t          c_q;
  sfs_core_t          c_d;
  logic               cs_fall;
  logic               cs_rise;
  logic               st_evt;
  logic               dn_evt;
  logic               idle;
  logic               frame_err;
  logic               bad;
  logic               rst_cmd;
  logic               evt;
  logic               sw_chg;
  logic               fault_sum;
  sfs_cmd_t           cmd;
  logic [FAULT_W-1:0] set_mask;
  logic [FAULT_W-1:0] clr_mask;
  logic [FAULT_W-1:0] fault_n;
  logic               clr_int;

  function automatic sfs_cmd_t cmd_of(input sfs_frame_t f);
    sfs_cmd_t k;
    k = CMD_OTHER;
    if (f.addr == ADDR_STATUS && !f.rw) begin
      k = CMD_STATUS;
    end else if (f.addr == ADDR_FAULT && !f.rw) begin
      k = CMD_FAULT;
    end else if (f.addr == ADDR_INTREQ && f.rw) begin
      k = CMD_INTREQ;
    end else if (f.addr == ADDR_RESET && f.rw) begin
      k = CMD_RESET;
    end
    return k;
  endfunction

  // Unknown address or non-zero data on a command write is malformed
  function automatic logic cmd_bad(input sfs_frame_t f, input sfs_cmd_t k);
    logic b;
    b = (k == CMD_OTHER);
    if ((k == CMD_INTREQ || k == CMD_RESET) && f.data != 24'h00_0000) begin
      b = 1'b1;
    end
    return b;
  endfunction

  // Link: sample mosi and launch miso on each sclk rising edge
  always_comb begin
    la_d     = la_q;
    lb_d     = lb_q;
    la_d.oe  = 1'b1;
    la_d.cnt = la_q.cnt + 5'd1;                          // [R18]
    la_d.sh  = {la_q.sh[29:0], mosi};
    if (la_q.cnt == 5'd0) begin
      // Reply word is frozen by the core while select is low
      la_d.miso  = c_q.resp[31];
      la_d.tx    = c_q.resp[30:0];
      lb_d.st_tg = ~lb_q.st_tg;
    end else begin
      la_d.miso = la_q.tx[30];
      la_d.tx   = {la_q.tx[29:0], 1'b0};
    end
    if (la_q.cnt == 5'(FRAME_BITS - 1)) begin             // [R18]
      lb_d.rx    = {la_q.sh, mosi};
      lb_d.dn_tg = ~lb_q.dn_tg;
    end
  end

  always_ff @(posedge sclk or posedge cs_b) begin
    if (cs_b) begin
      la_q <= '0;
    end else begin
      la_q <= la_d;
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      lb_q <= '0;
    end else begin
      lb_q <= lb_d;
    end
  end

  assign miso    = la_q.miso;
  assign miso_oe = la_q.oe;
  assign int_b   = c_q.int_b;

  // Core
  always_comb begin
    c_d         = c_q;
    c_d.cs_s    = {c_q.cs_s[1:0], cs_b};
    c_d.st_s    = {c_q.st_s[1:0], lb_q.st_tg};
    c_d.dn_s    = {c_q.dn_s[1:0], lb_q.dn_tg};
    c_d.sns_a   = sense_in;
    c_d.sns_b   = c_q.sns_a;
    c_d.sw_a    = sw_in;
    c_d.sw_b    = c_q.sw_a;
    c_d.sw_prev = c_q.sw_b;
    cs_fall     = c_q.cs_s[2] & ~c_q.cs_s[1];
    cs_rise     = ~c_q.cs_s[2] & c_q.cs_s[1];
    st_evt      = c_q.st_s[2] ^ c_q.st_s[1];
    dn_evt      = c_q.dn_s[2] ^ c_q.dn_s[1];
    idle        = c_q.cs_s[1];
    cmd         = cmd_of(lb_q.rx);
    bad         = dn_evt & cmd_bad(lb_q.rx, cmd);
    clr_mask    = '0;
    clr_int     = 1'b0;
    rst_cmd     = 1'b0;

    // Exactly one word per select window, else a length error
    if (cs_fall) begin
      c_d.starts = 2'd0;
      c_d.dones  = 2'd0;
    end else begin
      if (st_evt && c_q.starts != 2'd3) begin
        c_d.starts = c_q.starts + 2'd1;
      end
      if (dn_evt && c_q.dones != 2'd3) begin
        c_d.dones = c_q.dones + 2'd1;
      end
    end
    frame_err = cs_rise & ~(c_q.starts == 2'd1 && c_q.dones == 2'd1);

    if (dn_evt) begin
      // Clear only what the frame just shifted out actually showed
      case (c_q.prev)
        CMD_FAULT: begin
          clr_mask = c_q.resp[FAULT_W-1:0];                // [R04] [R10] [R11]
          if (bad) begin
            clr_mask[POS_SPI_ERR] = 1'b0;                  // [R05]
          end
          clr_int = c_q.resp[POS_INTFLG];                  // [R12]
        end
        CMD_STATUS, CMD_RESET: begin
          clr_int = c_q.resp[POS_INTFLG];                  // [R19]
        end
        default: clr_int = 1'b0;
      endcase
      c_d.prev     = cmd;
      rst_cmd      = (cmd == CMD_RESET) && !bad;           // [R16]
      // After a reset the reply is the switch status frame
      c_d.prev_hdr = rst_cmd ? {ADDR_STATUS, 1'b0}         // [R17]
                             : {lb_q.rx.addr, lb_q.rx.rw}; // [R14]
      if (cmd == CMD_INTREQ && !bad) begin
        c_d.pulse_cnt = TMR_W'(PULSE_CYC);                 // [R13]
      end
    end

    // Live conditions keep setting, so they win over a read clear
    set_mask              = '0;
    set_mask[POS_SPI_ERR] = frame_err | bad;               // [R05]
    set_mask[POS_HASH]    = hash_mismatch;                 // [R06]
    set_mask[POS_UV]      = c_q.sns_b.supply_low_flag;     // [R07]
    set_mask[POS_OV]      = c_q.sns_b.supply_high_flag;    // [R08]
    set_mask[POS_TWARN]   = c_q.sns_b.thermal_warning_flag; // [R09]
    set_mask[POS_TLIM]    = c_q.sns_b.thermal_limit_flag;  // [R09]
    set_mask[POS_WK_INT]  = wake_evt.int_pin_wake;         // [R10]
    set_mask[POS_WK_PIN]  = wake_evt.wake_pin_wake;        // [R10]
    set_mask[POS_WK_SPI]  = wake_evt.spi_msg_wake;         // [R10]
    set_mask[POS_POR]     = wake_evt.por_event;            // [R11]
    fault_n   = (rst_cmd ? FAULT_CMD_RST : (c_q.fault & ~clr_mask)) | set_mask;
    c_d.fault = fault_n;
    fault_sum = |c_q.fault;

    // Interrupt request path has no term here
    sw_chg     = c_q.sw_b != c_q.sw_prev;
    evt        = (|(fault_n & ~c_q.fault)) | sw_chg;       // [R12] [R15]
    c_d.intflg = ((rst_cmd ? 1'b0 : c_q.intflg) & ~clr_int) | evt; // [R12]

    // Reply is refreshed only while the link is idle
    if (idle) begin
      c_d.resp[31:24]       = c_q.prev_hdr;                // [R14]
      c_d.resp[POS_SUMMARY] = fault_sum;                   // [R01] [R20]
      c_d.resp[POS_INTFLG]  = c_q.intflg;                  // [R02]
      case (c_q.prev)
        CMD_FAULT: begin
          c_d.resp[21:0] = {11'h000, c_q.fault};           // [R04]
        end
        CMD_INTREQ: begin
          c_d.resp[21:0] = 22'h00_0000;                    // [R14]
        end
        default: begin
          c_d.resp[21:0] = c_q.sw_b;                       // [R03] [R17]
        end
      endcase
    end

    // Interrupt line: held low on events, released by a timer after select
    if (cs_fall) begin
      c_d.rel_run = 1'b1;
      c_d.rel_cnt = TMR_W'(RELEASE_CYC);
    end else if (c_q.rel_run) begin
      if (c_q.rel_cnt <= TMR_W'(1)) begin
        c_d.rel_run = 1'b0;
        c_d.int_low = |fault_n;                            // [R21]
      end else begin
        c_d.rel_cnt = c_q.rel_cnt - TMR_W'(1);
      end
    end
    if (evt) begin
      c_d.int_low = 1'b1;
    end
    if (c_q.pulse_cnt != '0 && c_d.pulse_cnt == c_q.pulse_cnt) begin
      c_d.pulse_cnt = c_q.pulse_cnt - TMR_W'(1);           // [R13]
    end
    c_d.int_b = ~(c_d.int_low | (c_d.pulse_cnt != '0));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      c_q                   <= '0;
      c_q.cs_s              <= CS_SYNC_RST;
      c_q.fault             <= FAULT_RST;
      c_q.intflg            <= INTFLG_RST;
      c_q.int_low           <= INTFLG_RST;
      c_q.resp[POS_SUMMARY] <= 1'b1;
      c_q.resp[POS_INTFLG]  <= INTFLG_RST;
    end else if (ce) begin
      c_q <= c_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_read_fault;
    ce && dn_evt && c_q.prev == CMD_FAULT;
  endsequence
  sequence s_read_status;
    ce && dn_evt && c_q.prev == CMD_STATUS;
  endsequence
  sequence s_int_req;
    ce && dn_evt && cmd == CMD_INTREQ && !bad;
  endsequence
  sequence s_reset_cmd;
    ce && dn_evt && cmd == CMD_RESET && !bad;
  endsequence

  a_summary_bit: assert property ( // [R01]
    ce && idle |=> c_q.resp[POS_SUMMARY] == $past(fault_sum))
    else $error("summary bit does not follow fault flags");
  a_change_bit: assert property ( // [R02]
    ce && idle |=> c_q.resp[POS_INTFLG] == $past(c_q.intflg))
    else $error("change bit not reported");
  a_switch_bits: assert property ( // [R03]
    ce && idle && c_q.prev == CMD_STATUS |=> c_q.resp[21:0] == $past(c_q.sw_b))
    else $error("switch states not reported");
  a_fault_reply: assert property ( // [R04]
    ce && idle && c_q.prev == CMD_FAULT
      |=> c_q.resp[21:0] == {11'h000, $past(c_q.fault)})
    else $error("fault flags not in reply");
  a_spi_err_set: assert property ( // [R05]
    ce && frame_err |=> c_q.fault[POS_SPI_ERR])
    else $error("length error not recorded");
  a_hash_hold: assert property ( // [R06]
    ce && hash_mismatch |=> c_q.fault[POS_HASH])
    else $error("hash flag dropped while mismatch present");
  a_uv_hold: assert property ( // [R07]
    ce && c_q.sns_b.supply_low_flag |=> c_q.fault[POS_UV])
    else $error("supply low flag dropped");
  a_ov_hold: assert property ( // [R08]
    ce && c_q.sns_b.supply_high_flag |=> c_q.fault[POS_OV])
    else $error("supply high flag dropped");
  a_temp_hold: assert property ( // [R09]
    ce && c_q.sns_b.thermal_limit_flag |=> c_q.fault[POS_TLIM])
    else $error("thermal limit flag dropped");
  a_wake_clear: assert property ( // [R10]
    s_read_fault ##0 (c_q.resp[POS_WK_PIN] && !wake_evt.wake_pin_wake)
      |=> !c_q.fault[POS_WK_PIN])
    else $error("wake flag not cleared on read");
  a_por_set: assert property ( // [R11]
    ce && wake_evt.por_event |=> c_q.fault[POS_POR])
    else $error("power-on flag not set");
  a_pulse_start: assert property ( // [R13]
    s_int_req |=> c_q.pulse_cnt == TMR_W'(PULSE_CYC) && !c_q.int_b)
    else $error("interrupt pulse not started");
  a_status_clear: assert property ( // [R19]
    s_read_status ##0 (c_q.resp[POS_INTFLG] && !evt) |=> !c_q.intflg)
    else $error("change flag not cleared by status read");
  a_reset_cmd: assert property ( // [R16]
    s_reset_cmd ##0 (set_mask == '0) |=> c_q.fault == FAULT_CMD_RST)
    else $error("reset command left fault flags");
  a_release_end: assert property ( // [R21]
    ce && !cs_fall && c_q.rel_run && c_q.rel_cnt <= TMR_W'(1) && !evt
      |=> c_q.int_low == $past(|fault_n))
    else $error("interrupt release wrong at timer end");
endmodule

// [testbench/sfs_host.sv]
// Host model: SPI master that runs one frame per call, 32 bits in xfer, n clocks in cut
module sfs_host (
  output logic      sclk,
  output logic      cs_b,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk = 1'b0;
    cs_b = 1'b0;
    mosi = 1'b0;
    // Rising select clears the link word before the first frame
    #1 cs_b = 1'b1;
  end

  // Cut frame: select window with too few clocks
  task automatic cut(input int n);
    #3 cs_b = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    #20 cs_b = 1'b1;
    #300;
  endtask

  // Clock stands low outside frames; 80 ns period
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
    #3;
    cs_b = 1'b0;
    #100;
    for (int i = 31; i >= 0; i--) begin
      mosi = cmd[i];
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
      rsp[i] = miso;
    end
    #20 cs_b = 1'b1;
    // Released line: inverse of last value
    mosi = ~mosi;
    #300;
  endtask
endmodule

// [testbench/sfs_top_tb.sv]
// Self-checking bench of the switch fault status block
module sfs_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sfs_pkg::*;

  localparam int PULSE = 20;
  localparam int REL   = 50;

  logic        clk = 1'b0;
  logic        rst = 1'b0;
  logic        ce  = 1'b1;
  logic        hash_mismatch = 1'b0;
  logic        sclk;
  logic        cs_b;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  logic        int_b;
  sfs_switch_t sw_in;
  sfs_sense_t  sense_in;
  sfs_wake_t   wake_evt;
  logic [31:0] rsp;
  logic [21:0] sw_exp = {8'ha5, 14'h1c3a};
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          len;

  always #5 clk = ~clk;

  sfs_top #(.PULSE_CYC(PULSE), .RELEASE_CYC(REL)) dut (
    .clk           (clk),
    .rst           (rst),
    .ce            (ce),
    .sclk          (sclk),
    .cs_b          (cs_b),
    .mosi          (mosi),
    .miso          (miso),
    .miso_oe       (miso_oe),
    .int_b         (int_b),
    .sw_in         (sw_in),
    .sense_in      (sense_in),
    .hash_mismatch (hash_mismatch),
    .wake_evt      (wake_evt)
  );

  sfs_host host (
    .sclk (sclk),
    .cs_b (cs_b),
    .mosi (mosi),
    .miso (miso)
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmd(input logic [6:0] a, input logic w,
                     input logic [23:0] d);
    host.xfer({a, w, d}, rsp);
  endtask

  // Fault read, then any frame whose reply carries the flags
  task automatic fault_pair(input logic [10:0] e);
    cmd(ADDR_FAULT, 1'b0, 24'h00_0000);
    cmd(ADDR_STATUS, 1'b0, 24'h00_0000);
    check("fault echo", 32'(rsp[31:24]), 32'h42);
    check("fault flags", {10'h000, rsp[21:0]}, {21'h00_0000, e});
  endtask

  task automatic wake_pulse(input logic [3:0] v);
    @(posedge clk) wake_evt <= v;
    @(posedge clk) wake_evt <= 4'h0;
    repeat (10) @(posedge clk);
  endtask

  task automatic measure_pulse(output int n);
    int k;
    n = 0;
    for (k = 0; k < 400 && int_b !== 1'b0; k++) @(negedge clk);
    if (k == 400) begin
      n_mismatch++;
      wrap_up();
    end
    while (int_b === 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask

  initial begin
    int k;
    // Rising reset clears the link toggles
    rst <= 1'b1;
    sense_in = '0;
    wake_evt = '0;
    sw_in = sw_exp;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    cmd(ADDR_STATUS, 1'b0, 24'h00_0000);
    check("summary", 32'(rsp[23]), 32'h1);
    check("change", 32'(rsp[22]), 32'h1);
    check("oe idle", 32'(miso_oe), 32'h0);
    cmd(ADDR_FAULT, 1'b0, 24'h00_0000);
    check("status echo", 32'(rsp[31:24]), 32'h3e);
    check("inputs", 32'(rsp[21:0]), 32'(sw_exp));
    cmd(ADDR_STATUS, 1'b0, 24'h00_0000);
    check("power-on flag", 32'(rsp[21:0]), 32'h1);
    check("summary held", 32'(rsp[23]), 32'h1);
    cmd(ADDR_STATUS, 1'b0, 24'h00_0000);
    check("summary clear", 32'(rsp[23]), 32'h0);
    check("inputs", 32'(rsp[21:0]), 32'(sw_exp));
    cmd(ADDR_STATUS, 1'b0, 24'h00_0000);
    check("change clear", 32'(rsp[22]), 32'h0);
    // Live conditions and wake events
    @(posedge clk) sense_in <= 4'hf;
    hash_mismatch <= 1'b1;
    wake_pulse(4'hf);
    fault_pair(11'h2ff);
    check("summary set", 32'(rsp[23]), 32'h1);
    @(posedge clk) sense_in <= 4'h0;
    hash_mismatch <= 1'b0;
    repeat (10) @(posedge clk);
    fault_pair(11'h2f0);
    fault_pair(11'h000);
    cmd(7'h30, 1'b0, 24'h00_0000);
    fault_pair(11'h400);
    fault_pair(11'h000);
    host.cut(8);
    fault_pair(11'h400);
    cmd(ADDR_STATUS, 1'b0, 24'h00_0000);
    for (k = 0; k < 600 && int_b !== 1'b1; k++) @(negedge clk);
    check("int idle", 32'(int_b), 32'h1);
    if (k == 600) begin
      wrap_up();
    end
    fork
      cmd(ADDR_INTREQ, 1'b1, 24'h00_0000);
      measure_pulse(len);
    join
    check("pulse length", 32'(len), 32'(PULSE));
    cmd(ADDR_STATUS, 1'b0, 24'h00_0000);
    check("intreq echo", 32'(rsp[31:24]), 32'h47);
    check("intreq body", 32'(rsp[21:0]), 32'h0);
    check("intreq change", 32'(rsp[22]), 32'h0);
    wake_pulse(4'h1);
    cmd(ADDR_RESET, 1'b1, 24'h00_0000);
    cmd(ADDR_STATUS, 1'b0, 24'h00_0000);
    check("reset echo", 32'(rsp[31:24]), 32'h3e);
    check("reset summary", 32'(rsp[23]), 32'h0);
    check("reset change", 32'(rsp[22]), 32'h0);
    check("reset body", 32'(rsp[21:0]), 32'(sw_exp));
    wrap_up();
  end
endmodule
